/* File: core/gfcs_freq_det.sv */
// frequency detector: counts sampled clock edges over a fixed interval
`timescale 1ns/1ps
`include "gfcs_regs.svh"
module gfcs_freq_det (
    // clock and reset
    input wire logic core_clk,
    input wire logic sys_rst,
    // measurement control
    input wire logic run,
    input wire logic clk_sample,
    input wire logic [7:0] expect_edges,
    input wire logic [7:0] window_pct,
    // result
    output logic meas_done,
    output logic freq_ok
);
    logic [9:0] tick;
    logic [8:0] edges;
    logic prev;
    logic rise;
    logic [15:0] tol;
    logic [15:0] lo;
    logic [15:0] hi;

    function automatic logic [15:0] pct_of(input logic [7:0] e, input logic [7:0] p);
        pct_of = ({8'h00, e} * {8'h00, p}) / `GFCS_PCT_DIV;
    endfunction : pct_of

    assign rise = clk_sample & ~prev;
    assign tol = pct_of(expect_edges, window_pct);
    assign lo = ({8'h00, expect_edges} > tol) ? {8'h00, expect_edges} - tol : 16'h0000;
    assign hi = {8'h00, expect_edges} + tol;

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            prev <= 1'b0;
        end else begin
            prev <= clk_sample;
        end
    end

    // no edges (with window_pct below 100 and expect_edges nonzero) or out-of-window count over one whole interval reads as not ok
    always_ff @(posedge core_clk) begin
        if (sys_rst || !run) begin
            tick <= 10'h000;
            edges <= 9'h000;
            meas_done <= 1'b0;
            freq_ok <= 1'b0;
        end else begin
            tick <= tick + 10'h001;
            meas_done <= 1'b0;
            if (tick == `GFCS_MEAS_LAST) begin
                meas_done <= 1'b1;
                freq_ok <= ({7'h00, edges} >= lo) && ({7'h00, edges} <= hi);
                edges <= 9'h000;
            end else if (rise && edges != 9'h1FF) begin
                edges <= edges + 9'h001;
            end
        end
    end
endmodule : gfcs_freq_det

/* File: core/gfcs_pkg.sv */
// types for the pin function and clock sync block
package gfcs_pkg;
    typedef enum logic [3:0] {
        GFCS_ST_BOOT = 4'b0001,
        GFCS_ST_SEARCH = 4'b0010,
        GFCS_ST_EXT = 4'b0100,
        GFCS_ST_INT = 4'b1000
    } gfcs_clk_state_t;
    typedef enum logic [2:0] {
        GFCS_PIN_INPUT, GFCS_PIN_OUTPUT, GFCS_PIN_EXT_CLK, GFCS_PIN_CLK_OUT,
        GFCS_PIN_SYNC_OUT, GFCS_PIN_RAIL_EN, GFCS_PIN_PGOOD, GFCS_PIN_FAULT
    } gfcs_pin_class_t;
endpackage : gfcs_pkg

/* File: core/gfcs_regs.svh */
// register indices, reset values and counts for the pin function and clock sync block
`ifndef GFCS_REGS_SVH
`define GFCS_REGS_SVH
`define GFCS_REG_POLARITY 8'h00
`define GFCS_REG_SYNC_MODE 8'h01
`define GFCS_REG_WINDOW 8'h02
`define GFCS_REG_RAIL_EN 8'h03
`define GFCS_REG_GPO 8'h04
`define GFCS_REG_PG_DELAY 8'h05
`define GFCS_REG_PERIOD 8'h06
`define GFCS_REG_EXPECT 8'h07
`define GFCS_REG_FUNC0 8'h08
`define GFCS_REG_FUNC5 8'h0D
`define GFCS_REG_RAIL_GOOD 8'h10
`define GFCS_REG_CLK_STATUS 8'h11
`define GFCS_SYNC_USE_EXT 0
`define GFCS_SYNC_AUTO_BACK 1
`define GFCS_SYNC_MASTER 2
`define GFCS_SYNC_FOLLOWER 3
`define GFCS_POL_LOCK_MASK 6'h30
`define GFCS_POLARITY_RESET 6'h00
`define GFCS_SYNC_MODE_RESET 4'h0
`define GFCS_WINDOW_RESET 8'h05
`define GFCS_PG_DELAY_RESET 8'h00
`define GFCS_PERIOD_RESET 8'h40
`define GFCS_EXPECT_RESET 8'h80
`define GFCS_FUNC_RESET 8'h00
`define GFCS_MEAS_LAST 10'h3FF
`define GFCS_PCT_DIV 16'h0064
`define GFCS_CLKOUT_HALF 4'h3
`define GFCS_FAULT_COUNT 5'h12
`define GFCS_CODE_OUTPUT 8'h01
`define GFCS_CODE_EXT_CLK 8'h02
`define GFCS_CODE_CLK_OUT 8'h03
`define GFCS_CODE_SYNC_OUT 8'h04
`endif

/* File: core/gfcs_top.sv */
// pin function mapping, polarity, rail control and clock source selection
`timescale 1ns/1ps
`include "gfcs_regs.svh"
// Summary of operation
// - always start on the internal clock; consider the external source afterwards.
// - switch to external clock only when its measured frequency is inside the window.
// - no in-window clock found means staying on the internal clock.
// - with automatic switch back, a failing external clock returns to internal clock.
// - master drives clock and sync outputs on configured pins once configuration loaded.
// - follower runs internal during configuration load, then adopts the master clock.
// - four channels tick at quarter-period phase offsets within each period.
// - each pin's function comes from one-time bits or a serial-bus write.
// - six polarity bits invert pins 0 to 5 individually, inputs and outputs.
// - in serial-bus mode, writes to polarity bits 5 and 4 are ignored.
// - rail-enable pin turns its selected rails on when asserted, off otherwise.
// - rails may also be enabled and disabled by register writes.
// - power-good pin asserts only while all its mapped rails are good.
// - per-rail power-good information is readable in a status register.
// - fault pin shows exactly one selected fault or warning condition.
// - rail good needs in-bounds voltage; its delay starts after soft-start completes.
module gfcs_top
    import gfcs_pkg::*;
(
    // clock and reset
    input wire logic core_clk,
    input wire logic sys_rst,
    // register port from the serial-bus front end
    input wire logic reg_wr,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    input wire logic serial_bus_mode,
    // configuration memory
    input wire logic cfg_loaded,
    input wire logic otp_load,
    input wire logic [47:0] otp_func,
    input wire logic [5:0] otp_polarity,
    // pins
    input wire logic [5:0] pin_in,
    output logic [5:0] pin_out,
    output logic [5:0] pin_oe,
    // rails and protection
    input wire logic [4:0] rail_in_bounds,
    input wire logic [4:0] soft_start_done,
    input wire logic [17:0] fault_in,
    output logic [4:0] rail_en,
    // clocking
    output logic clk_use_ext,
    output logic [3:0] phase_tick
);
    gfcs_clk_state_t state;
    logic [5:0] pin_polarity_select;
    logic [3:0] sync_mode;
    logic [7:0] window_pct;
    logic [4:0] rail_en_reg;
    logic [5:0] gpo;
    logic [7:0] pg_delay;
    logic [7:0] period;
    logic [7:0] expect_edges;
    logic [7:0] pin_function_select [6];
    logic [4:0] rail_good_status;
    logic [7:0] pg_cnt [5];
    logic ext_fail;
    logic [7:0] ph_cnt;
    logic [3:0] div_cnt;
    logic clk_div;
    logic [5:0] pin_act;
    logic [5:0] next_out;
    logic [5:0] next_oe;
    logic [4:0] pin_rail_req;
    logic ext_sample;
    logic det_run;
    logic meas_done;
    logic freq_ok;
    logic use_ext;
    logic master_drive;
    logic pol_wr;
    logic [5:0] clkout_pins;

    function automatic gfcs_pin_class_t pin_class(input logic [7:0] code);
        if (code[7]) pin_class = GFCS_PIN_FAULT;
        else if (code[6]) pin_class = GFCS_PIN_PGOOD;
        else if (code[5]) pin_class = GFCS_PIN_RAIL_EN;
        else if (code == `GFCS_CODE_OUTPUT) pin_class = GFCS_PIN_OUTPUT;
        else if (code == `GFCS_CODE_EXT_CLK) pin_class = GFCS_PIN_EXT_CLK;
        else if (code == `GFCS_CODE_CLK_OUT) pin_class = GFCS_PIN_CLK_OUT;
        else if (code == `GFCS_CODE_SYNC_OUT) pin_class = GFCS_PIN_SYNC_OUT;
        else pin_class = GFCS_PIN_INPUT;
    endfunction : pin_class

    assign pin_act = pin_in ^ pin_polarity_select;
    assign use_ext = sync_mode[`GFCS_SYNC_USE_EXT] | sync_mode[`GFCS_SYNC_FOLLOWER];
    assign master_drive = sync_mode[`GFCS_SYNC_MASTER] & cfg_loaded;
    assign det_run = (state == GFCS_ST_SEARCH) || (state == GFCS_ST_EXT);
    assign pol_wr = reg_wr && reg_addr == `GFCS_REG_POLARITY;

    // register writes and one-time-bit load
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            pin_polarity_select <= `GFCS_POLARITY_RESET;
            sync_mode <= `GFCS_SYNC_MODE_RESET;
            window_pct <= `GFCS_WINDOW_RESET;
            rail_en_reg <= 5'h00;
            gpo <= 6'h00;
            pg_delay <= `GFCS_PG_DELAY_RESET;
            period <= `GFCS_PERIOD_RESET;
            expect_edges <= `GFCS_EXPECT_RESET;
            for (int i = 0; i < 6; i++) pin_function_select[i] <= `GFCS_FUNC_RESET;
        end else if (otp_load) begin
            pin_polarity_select <= otp_polarity;
            for (int i = 0; i < 6; i++) pin_function_select[i] <= otp_func[i*8 +: 8];
        end else if (reg_wr) begin
            case (reg_addr)
                `GFCS_REG_POLARITY: begin
                    if (serial_bus_mode) begin
                        pin_polarity_select <= (pin_polarity_select & `GFCS_POL_LOCK_MASK)
                            | (reg_wdata[5:0] & ~`GFCS_POL_LOCK_MASK);
                    end else begin
                        pin_polarity_select <= reg_wdata[5:0];
                    end
                end
                `GFCS_REG_SYNC_MODE: sync_mode <= reg_wdata[3:0];
                `GFCS_REG_WINDOW: window_pct <= reg_wdata;
                `GFCS_REG_RAIL_EN: rail_en_reg <= reg_wdata[4:0];
                `GFCS_REG_GPO: gpo <= reg_wdata[5:0];
                `GFCS_REG_PG_DELAY: pg_delay <= reg_wdata;
                `GFCS_REG_PERIOD: period <= reg_wdata;
                `GFCS_REG_EXPECT: expect_edges <= reg_wdata;
                default: begin
                    if (reg_addr >= `GFCS_REG_FUNC0 && reg_addr <= `GFCS_REG_FUNC5) begin
                        pin_function_select[3'(reg_addr - `GFCS_REG_FUNC0)] <= reg_wdata;
                    end
                end
            endcase
        end
    end

    // read data, unmapped addresses read zero
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            reg_rdata <= 8'h00;
        end else begin
            case (reg_addr)
                `GFCS_REG_POLARITY: reg_rdata <= {2'h0, pin_polarity_select};
                `GFCS_REG_SYNC_MODE: reg_rdata <= {4'h0, sync_mode};
                `GFCS_REG_WINDOW: reg_rdata <= window_pct;
                `GFCS_REG_RAIL_EN: reg_rdata <= {3'h0, rail_en_reg};
                `GFCS_REG_GPO: reg_rdata <= {2'h0, gpo};
                `GFCS_REG_PG_DELAY: reg_rdata <= pg_delay;
                `GFCS_REG_PERIOD: reg_rdata <= period;
                `GFCS_REG_EXPECT: reg_rdata <= expect_edges;
                `GFCS_REG_RAIL_GOOD: reg_rdata <= {3'h0, rail_good_status};
                `GFCS_REG_CLK_STATUS: reg_rdata <= {4'h0, ext_fail, clk_use_ext, det_run, cfg_loaded};
                default: begin
                    if (reg_addr >= `GFCS_REG_FUNC0 && reg_addr <= `GFCS_REG_FUNC5) begin
                        reg_rdata <= pin_function_select[3'(reg_addr - `GFCS_REG_FUNC0)];
                    end else begin
                        reg_rdata <= 8'h00;
                    end
                end
            endcase
        end
    end

    // external clock taken from whichever pins are set as clock input
    always_comb begin
        ext_sample = 1'b0;
        clkout_pins = 6'h00;
        for (int i = 0; i < 6; i++) begin
            if (pin_class(pin_function_select[i]) == GFCS_PIN_EXT_CLK) ext_sample = ext_sample | pin_act[i];
            if (pin_class(pin_function_select[i]) == GFCS_PIN_CLK_OUT) clkout_pins[i] = 1'b1;
        end
    end

    gfcs_freq_det u_freq_det (
        .core_clk(core_clk),
        .sys_rst(sys_rst),
        .run(det_run),
        .clk_sample(ext_sample),
        .expect_edges(expect_edges),
        .window_pct(window_pct),
        .meas_done(meas_done),
        .freq_ok(freq_ok)
    );

    // clock source selection
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            state <= GFCS_ST_BOOT;
        end else begin
            case (state)
                GFCS_ST_BOOT: begin
                    if (cfg_loaded) state <= use_ext ? GFCS_ST_SEARCH : GFCS_ST_INT;
                end
                GFCS_ST_SEARCH: begin
                    if (meas_done && freq_ok) state <= GFCS_ST_EXT;
                end
                GFCS_ST_EXT: begin
                    if (meas_done && !freq_ok && sync_mode[`GFCS_SYNC_AUTO_BACK]) state <= GFCS_ST_INT;
                end
                GFCS_ST_INT: state <= GFCS_ST_INT;
                default: state <= GFCS_ST_BOOT;
            endcase
        end
    end

    assign clk_use_ext = (state == GFCS_ST_EXT);

    // sticky failure flag, write one to clear; a new failure wins
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            ext_fail <= 1'b0;
        end else if (state == GFCS_ST_EXT && meas_done && !freq_ok) begin
            ext_fail <= 1'b1;
        end else if (reg_wr && reg_addr == `GFCS_REG_CLK_STATUS && reg_wdata[3]) begin
            ext_fail <= 1'b0;
        end
    end

    // channel phase ticks at quarter-period offsets
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            ph_cnt <= 8'h00;
            phase_tick <= 4'h0;
        end else begin
            ph_cnt <= (ph_cnt >= period - 8'h01) ? 8'h00 : ph_cnt + 8'h01;
            for (int k = 0; k < 4; k++) begin
                phase_tick[k] <= (ph_cnt == 8'(k * {2'h0, period[7:2]}));
            end
        end
    end

    // master clock output divider
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            div_cnt <= 4'h0;
            clk_div <= 1'b0;
        end else if (div_cnt == `GFCS_CLKOUT_HALF) begin
            div_cnt <= 4'h0;
            clk_div <= ~clk_div;
        end else begin
            div_cnt <= div_cnt + 4'h1;
        end
    end

    // per-rail good with delay started after soft-start
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            rail_good_status <= 5'h00;
            for (int r = 0; r < 5; r++) pg_cnt[r] <= 8'h00;
        end else begin
            for (int r = 0; r < 5; r++) begin
                if (!(rail_in_bounds[r] && soft_start_done[r])) begin
                    pg_cnt[r] <= 8'h00;
                    rail_good_status[r] <= 1'b0;
                end else if (pg_cnt[r] >= pg_delay) begin
                    rail_good_status[r] <= 1'b1;
                end else begin
                    pg_cnt[r] <= pg_cnt[r] + 8'h01;
                end
            end
        end
    end

    // pin output functions, active high before polarity
    always_comb begin
        next_out = 6'h00;
        next_oe = 6'h00;
        pin_rail_req = 5'h00;
        for (int i = 0; i < 6; i++) begin
            case (pin_class(pin_function_select[i]))
                GFCS_PIN_OUTPUT: begin
                    next_out[i] = gpo[i];
                    next_oe[i] = 1'b1;
                end
                GFCS_PIN_CLK_OUT: begin
                    next_out[i] = clk_div;
                    next_oe[i] = master_drive;
                end
                GFCS_PIN_SYNC_OUT: begin
                    next_out[i] = phase_tick[0];
                    next_oe[i] = master_drive;
                end
                GFCS_PIN_RAIL_EN: begin
                    if (pin_act[i]) pin_rail_req = pin_rail_req | pin_function_select[i][4:0];
                end
                GFCS_PIN_PGOOD: begin
                    next_out[i] = &(rail_good_status | ~pin_function_select[i][4:0]);
                    next_oe[i] = 1'b1;
                end
                GFCS_PIN_FAULT: begin
                    if (pin_function_select[i][4:0] < `GFCS_FAULT_COUNT) begin
                        next_out[i] = fault_in[pin_function_select[i][4:0]];
                    end
                    next_oe[i] = 1'b1;
                end
                default: next_oe[i] = 1'b0;
            endcase
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            pin_out <= 6'h00;
            pin_oe <= 6'h00;
            rail_en <= 5'h00;
        end else begin
            pin_out <= next_out ^ pin_polarity_select;
            pin_oe <= next_oe;
            rail_en <= rail_en_reg | pin_rail_req;
        end
    end

    a_boot_internal: assert property (@(posedge core_clk) disable iff (sys_rst)
        state == GFCS_ST_BOOT |-> !clk_use_ext) else $error("external clock used before boot done");
    a_switch_cause: assert property (@(posedge core_clk) disable iff (sys_rst)
        $rose(clk_use_ext) |-> $past(meas_done) && $past(freq_ok)) else $error("switch without in-window result");
    a_stay_internal: assert property (@(posedge core_clk) disable iff (sys_rst)
        state == GFCS_ST_SEARCH && meas_done && !freq_ok |=> !clk_use_ext) else $error("bad clock adopted");
    a_auto_back: assert property (@(posedge core_clk) disable iff (sys_rst)
        clk_use_ext && meas_done && !freq_ok && sync_mode[`GFCS_SYNC_AUTO_BACK] |=> !clk_use_ext && ext_fail)
        else $error("no switch back after clock failure");
    a_master_drive: assert property (@(posedge core_clk) disable iff (sys_rst)
        master_drive && |clkout_pins |=> |(pin_oe & $past(clkout_pins))) else $error("master clock pin not driven");
    a_follower_boot: assert property (@(posedge core_clk) disable iff (sys_rst)
        !cfg_loaded && $past(!cfg_loaded) |-> !clk_use_ext) else $error("external clock during config load");
    a_phase_onehot: assert property (@(posedge core_clk) disable iff (sys_rst)
        period >= 8'h04 && $stable(period) |-> $onehot0(phase_tick)) else $error("phase ticks overlap");
    a_pol_locked: assert property (@(posedge core_clk) disable iff (sys_rst)
        pol_wr && serial_bus_mode && !otp_load |=> $stable(pin_polarity_select[5:4])) else $error("locked polarity changed");
    a_good_cause: assert property (@(posedge core_clk) disable iff (sys_rst)
        (rail_good_status & ~$past(rail_in_bounds & soft_start_done)) == 5'h00) else $error("rail good without cause");
    a_rail_follow: assert property (@(posedge core_clk) disable iff (sys_rst)
        reg_wr && reg_addr == `GFCS_REG_RAIL_EN && !otp_load |=> ##1 (rail_en & $past(reg_wdata[4:0], 2)) == $past(reg_wdata[4:0], 2))
        else $error("rail enable write not applied");
endmodule : gfcs_top

/* File: sim/gfcs_clk_src.sv */
// external clock source standing in for the board or a master device
`timescale 1ns/1ps
module gfcs_clk_src (
    // clock
    input wire logic core_clk,
    // control
    input wire logic run,
    input wire logic [3:0] half,
    // clock toward the pin
    output logic ext_clk
);
    logic [3:0] cnt;
    initial begin
        cnt = 4'h0;
        ext_clk = 1'b0;
    end
    // stands low while stopped
    always @(posedge core_clk) begin
        if (!run) begin
            cnt <= 4'h0;
            ext_clk <= 1'b0;
        end else if (cnt == half - 4'h1) begin
            cnt <= 4'h0;
            ext_clk <= ~ext_clk;
        end else begin
            cnt <= cnt + 4'h1;
        end
    end
endmodule : gfcs_clk_src

/* File: sim/gpio_func_and_clock_sync_bench.sv */
// self-checking bench for the pin function and clock sync block
`timescale 1ns/1ps
`include "gfcs_regs.svh"
`define CHK(nm, exp, got) begin \
    comparisons++; \
    if ((got) !== (exp)) begin \
        err_count++; \
        $display("CHECK FAILED %s expected %0h seen %0h", nm, exp, got); \
    end \
end
module gpio_func_and_clock_sync_bench;
    logic core_clk = 1'b0, sys_rst = 1'b1, reg_wr = 1'b0, serial_bus_mode = 1'b0;
    logic cfg_loaded = 1'b0, otp_load = 1'b0, src_run = 1'b0, ext_clk;
    logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
    logic [47:0] otp_func = 48'h000000000000;
    logic [5:0] otp_polarity = 6'h00, pin_drive = 6'h00, pin_in, pin_out, pin_oe;
    logic [4:0] rail_in_bounds = 5'h00, soft_start_done = 5'h00, rail_en;
    logic [17:0] fault_in = 18'h00000;
    logic [3:0] half = 4'h4, phase_tick;
    logic clk_use_ext;
    int err_count = 0, comparisons = 0, cycles = 0;
    always #4 core_clk = ~core_clk;
    assign pin_in = {pin_drive[5], ext_clk, pin_drive[3:0]};
    gfcs_top gfcs_top_i (.core_clk(core_clk), .sys_rst(sys_rst), .reg_wr(reg_wr), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .serial_bus_mode(serial_bus_mode),
        .cfg_loaded(cfg_loaded), .otp_load(otp_load), .otp_func(otp_func), .otp_polarity(otp_polarity),
        .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .rail_in_bounds(rail_in_bounds),
        .soft_start_done(soft_start_done), .fault_in(fault_in), .rail_en(rail_en),
        .clk_use_ext(clk_use_ext), .phase_tick(phase_tick));
    gfcs_clk_src gfcs_clk_src_i (.core_clk(core_clk), .run(src_run), .half(half), .ext_clk(ext_clk));
    task automatic give_verdict;
        $display("comparisons %0d mismatches %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : give_verdict
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 40000) begin
            err_count++;
            give_verdict();
        end
    end
    task automatic step(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask : step
    task automatic rst(input int n);
        sys_rst = 1'b1;
        cfg_loaded = 1'b0;
        src_run = 1'b0;
        step(n);
        sys_rst = 1'b0;
    endtask : rst
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        step(1);
        reg_wr = 1'b0;
    endtask : wr
    task automatic chk_reg(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
        reg_addr = a;
        step(1);
        `CHK("register", e, reg_rdata & m)
    endtask : chk_reg
    task automatic wait_ext(input logic v, input int lim);
        int n;
        n = 0;
        while (clk_use_ext !== v && n < lim) begin
            step(1);
            n++;
        end
    endtask : wait_ext
    task automatic t_reset;
        rst(2);
        chk_reg(`GFCS_REG_WINDOW, 8'hFF, `GFCS_WINDOW_RESET);
        chk_reg(`GFCS_REG_PERIOD, 8'hFF, `GFCS_PERIOD_RESET);
        chk_reg(`GFCS_REG_EXPECT, 8'hFF, `GFCS_EXPECT_RESET);
        chk_reg(`GFCS_REG_FUNC0, 8'hFF, `GFCS_FUNC_RESET);
        chk_reg(8'h20, 8'hFF, 8'h00);
        `CHK("rail_en", 5'h00, rail_en)
        otp_func = 48'h000001000000;
        otp_polarity = 6'h02;
        otp_load = 1'b1;
        step(1);
        otp_load = 1'b0;
        chk_reg(8'h0B, 8'hFF, `GFCS_CODE_OUTPUT);
        chk_reg(`GFCS_REG_POLARITY, 8'h3F, 8'h02);
    endtask : t_reset
    task automatic t_polarity;
        rst(2);
        for (int i = 0; i < 6; i++) wr(`GFCS_REG_FUNC0 + 8'(i), `GFCS_CODE_OUTPUT);
        wr(`GFCS_REG_GPO, 8'h05);
        step(3);
        `CHK("pin_oe", 6'h3F, pin_oe)
        `CHK("pin_out", 6'h05, pin_out)
        serial_bus_mode = 1'b1;
        wr(`GFCS_REG_POLARITY, 8'h3F);
        chk_reg(`GFCS_REG_POLARITY, 8'h3F, 8'h0F);
        step(3);
        `CHK("pin_out", 6'h0A, pin_out)
        serial_bus_mode = 1'b0;
        wr(`GFCS_REG_POLARITY, 8'h3F);
        step(3);
        `CHK("pin_out", 6'h3A, pin_out)
    endtask : t_polarity
    task automatic t_rails;
        rst(2);
        wr(`GFCS_REG_RAIL_EN, 8'h01);
        step(2);
        `CHK("rail_en", 5'h01, rail_en)
        wr(`GFCS_REG_RAIL_EN, 8'h00);
        wr(8'h09, 8'h32);
        pin_drive[1] = 1'b1;
        step(3);
        `CHK("rail_en", 5'h12, rail_en)
        pin_drive[1] = 1'b0;
        step(3);
        `CHK("rail_en", 5'h00, rail_en)
        wr(`GFCS_REG_POLARITY, 8'h02);
        step(3);
        `CHK("rail_en", 5'h12, rail_en)
    endtask : t_rails
    task automatic t_pgood;
        rst(2);
        wr(8'h0A, 8'h43);
        rail_in_bounds = 5'h03;
        soft_start_done = 5'h01;
        step(4);
        `CHK("pgood", 1'b0, pin_out[2])
        chk_reg(`GFCS_REG_RAIL_GOOD, 8'h1F, 8'h01);
        soft_start_done = 5'h03;
        step(4);
        `CHK("pgood", 1'b1, pin_out[2])
        chk_reg(`GFCS_REG_RAIL_GOOD, 8'h1F, 8'h03);
        rail_in_bounds = 5'h02;
        wr(`GFCS_REG_PG_DELAY, 8'h0A);
        step(3);
        `CHK("pgood", 1'b0, pin_out[2])
        rail_in_bounds = 5'h03;
        step(4);
        `CHK("pgood", 1'b0, pin_out[2])
        step(10);
        `CHK("pgood", 1'b1, pin_out[2])
    endtask : t_pgood
    task automatic t_fault;
        rst(2);
        for (int s = 0; s < 18; s++) begin
            wr(8'h0B, 8'h80 | 8'(s));
            fault_in = 18'h00001 << s;
            step(3);
            `CHK("fault", 1'b1, pin_out[3])
            fault_in = ~(18'h00001 << s);
            step(3);
            `CHK("fault", 1'b0, pin_out[3])
        end
        fault_in = 18'h00000;
    endtask : t_fault
    task automatic t_ext_clk;
        rst(2);
        wr(8'h0C, `GFCS_CODE_EXT_CLK);
        wr(`GFCS_REG_SYNC_MODE, 8'h03);
        half = 4'h4;
        src_run = 1'b1;
        step(1100);
        `CHK("use_ext", 1'b0, clk_use_ext)
        cfg_loaded = 1'b1;
        wait_ext(1'b1, 2200);
        `CHK("use_ext", 1'b1, clk_use_ext)
        src_run = 1'b0;
        wait_ext(1'b0, 2200);
        `CHK("use_ext", 1'b0, clk_use_ext)
        chk_reg(`GFCS_REG_CLK_STATUS, 8'h08, 8'h08);
        wr(`GFCS_REG_CLK_STATUS, 8'h08);
        chk_reg(`GFCS_REG_CLK_STATUS, 8'h08, 8'h00);
        rst(2);
        wr(8'h0C, `GFCS_CODE_EXT_CLK);
        wr(`GFCS_REG_SYNC_MODE, 8'h01);
        half = 4'h5;
        src_run = 1'b1;
        cfg_loaded = 1'b1;
        step(2600);
        `CHK("use_ext", 1'b0, clk_use_ext)
    endtask : t_ext_clk
    task automatic t_follower;
        rst(2);
        wr(8'h0C, `GFCS_CODE_EXT_CLK);
        wr(`GFCS_REG_SYNC_MODE, 8'h08);
        half = 4'h4;
        src_run = 1'b1;
        step(1100);
        `CHK("use_ext", 1'b0, clk_use_ext)
        cfg_loaded = 1'b1;
        wait_ext(1'b1, 2200);
        `CHK("use_ext", 1'b1, clk_use_ext)
    endtask : t_follower
    task automatic t_master;
        int rises, syncs, n;
        logic pc, ps;
        rst(2);
        wr(8'h0D, `GFCS_CODE_CLK_OUT);
        wr(`GFCS_REG_FUNC0, `GFCS_CODE_SYNC_OUT);
        wr(`GFCS_REG_SYNC_MODE, 8'h04);
        step(4);
        `CHK("clk_oe", 1'b0, pin_oe[5])
        cfg_loaded = 1'b1;
        step(4);
        `CHK("clk_oe", 1'b1, pin_oe[5])
        rises = 0;
        syncs = 0;
        pc = pin_out[5];
        ps = pin_out[0];
        repeat (128) begin
            step(1);
            if (pin_out[5] && !pc) rises++;
            if (pin_out[0] && !ps) syncs++;
            pc = pin_out[5];
            ps = pin_out[0];
        end
        `CHK("clk_out", 16, rises)
        `CHK("sync_out", 2, syncs)
        n = 0;
        while (phase_tick[0] !== 1'b1 && n < 200) begin
            step(1);
            n++;
        end
        for (int k = 1; k < 4; k++) begin
            n = 0;
            while (phase_tick[k] !== 1'b1 && n < 100) begin
                step(1);
                n++;
            end
            `CHK("phase", 16, n)
        end
    endtask : t_master
    initial begin
        rst(16);
        t_reset();
        t_polarity();
        t_rails();
        t_pgood();
        t_fault();
        t_ext_clk();
        t_follower();
        t_master();
        give_verdict();
    end
endmodule : gpio_func_and_clock_sync_bench
